// *** design/dual_timer_shift_unit.v ***
// two down-counting timers and a serial shift register behind an ahb-lite slave
// Function
// - one-shot with pin enabled: timer1 high write drives timer pin low until zero.
// - timer1 high write clears flag, loads low counter from latch, starts counting.
// - one-shot timer1 flags once at zero, keeps counting, no reflag until the next high counter write.
// - one-shot timer1 latch-high write leaves count and pin untouched.
// - free-run: at zero set flag, toggle pin, reload 16 bits, keep counting.
// - timer1 flag clears on high write, low count read, or writing one.
// - writing a timer high counter byte restarts its period; retriggerable.
// - latch-only writes never disturb the running count; they set the next period.
// - timer pin carries timer output only if direction bit 7 and enable both set.
// - one aux control bit selects timer2 interval or pulse counting mode.
// - timer2 has write latch low, read counter low, read/write counter high.
// - timer2 one-shot flags once per high write, keeps counting afterwards.
// - timer2 flag clears on timer2 low count read or high count write.
// - pulse mode: high write arms, count negative pulses, flag once passing zero.
// - shift register moves data on line b2, modulo-8 counter, clocks on line b1.
// - mode 0: register accessible, shifts line b2 on line b1 rising, flag zero.
// - mode 1: shift rate from timer2 low latch, clock driven on line b1.
// - mode 1: any access clears flag and starts shifting at the next divider tick.
// - mode 1: bit 7 first, capture after b1 rising, flag after 8 pulses.
// - mode 2: access starts shifting at half the clock rate, flag and stop after 8.
// - interrupt request low while any enabled flag is set.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_map.vh"
module dual_timer_shift_unit (
  input wire core_clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg port_b_bit7_timer_pin,
  output reg port_b_bit7_oe,
  input wire port_b_bit6_count_pin,
  input wire ctrl_line_b1_in,
  output reg ctrl_line_b1_out,
  output reg ctrl_line_b1_oe,
  input wire ctrl_line_b2,
  output wire irq_n
);
  reg [7:0] port_b_output_latch_q;
  reg [7:0] port_b_direction_q;
  reg [7:0] aux_control_reg_q;
  reg [6:0] ienable_q;
  reg [7:0] t1_lat_lo_q;
  reg [7:0] t1_lat_hi_q;
  reg [15:0] t1_cnt_q;
  reg t1_armed_q;
  reg t1_out_q;
  reg t1_flag_q;
  reg [7:0] t2_lat_lo_q;
  reg [15:0] t2_cnt_q;
  reg t2_armed_q;
  reg t2_flag_q;
  reg [7:0] serial_shift_reg_q;
  reg [3:0] sr_cnt_q;
  reg sr_run_q;
  reg sr_flag_q;
  reg sr_clk_q;
  reg [7:0] sr_div_q;
  reg [1:0] sr_cap_q;
  reg [7:0] rdata_q;
  reg [31:0] hrdata_q;
  // address phase capture
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire b1_level;
  wire b1_rise;
  wire pb6_fall;
  wire t1_free = aux_control_reg_q[`BIT_T1_FREE];
  wire t2_pulse = aux_control_reg_q[`BIT_T2_PULSE];
  wire [2:0] sr_mode = aux_control_reg_q[`FLD_SR_MODE_HI:`FLD_SR_MODE_LO];
  wire rd_now = hsel && hready && htrans[1] && !hwrite;
  wire [7:0] rd_addr = haddr[7:0];
  wire [7:0] wd = hwdata[7:0];
  wire wr_t1_hi = wr_pend_q && (wr_addr_q == `OFS_T1_CNT_HI);
  wire wr_t1_lat_hi = wr_pend_q && (wr_addr_q == `OFS_T1_LAT_HI);
  wire wr_t1_lo = wr_pend_q && (wr_addr_q == `OFS_T1_CNT_LO || wr_addr_q == `OFS_T1_LAT_LO);
  wire wr_t2_hi = wr_pend_q && (wr_addr_q == `OFS_T2_CNT_HI);
  wire wr_t2_lo = wr_pend_q && (wr_addr_q == `OFS_T2_CNT_LO);
  wire wr_sr = wr_pend_q && (wr_addr_q == `OFS_SHIFT);
  wire wr_flag = wr_pend_q && (wr_addr_q == `OFS_IFLAG);
  wire rd_t1_lo = rd_now && (rd_addr == `OFS_T1_CNT_LO);
  wire rd_t2_lo = rd_now && (rd_addr == `OFS_T2_CNT_LO);
  wire rd_sr = rd_now && (rd_addr == `OFS_SHIFT);
  wire sr_access = wr_sr || rd_sr;
  wire t1_zero = (t1_cnt_q == 16'h0000);
  wire t2_dec = t2_pulse ? pb6_fall : 1'b1;
  wire t2_zero = (t2_cnt_q == 16'h0000) && t2_dec;
  wire [6:0] flags = {t1_flag_q, t2_flag_q, 2'b00, sr_flag_q, 2'b00};
  wire any_irq = |(flags & ienable_q);

  edge_sync b1_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(ctrl_line_b1_in),
    .level(b1_level),
    .rise(b1_rise),
    .fall()
  );
  edge_sync pb6_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(port_b_bit6_count_pin),
    .level(),
    .rise(),
    .fall(pb6_fall)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq_n = !any_irq;

  // bus slave: writes land one cycle after the address phase, reads answer in the data phase
  always @(posedge core_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= `RST_BYTE;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr[7:0];
      if (rd_now) begin
        hrdata_q <= {24'h000000, rdata_q};
      end
    end
  end

  always @* begin
    case (rd_addr)
      `OFS_PORT_B_OUT: rdata_q = port_b_output_latch_q;
      `OFS_PORT_B_DIR: rdata_q = port_b_direction_q;
      `OFS_T1_CNT_LO: rdata_q = t1_cnt_q[7:0];
      `OFS_T1_CNT_HI: rdata_q = t1_cnt_q[15:8];
      `OFS_T1_LAT_LO: rdata_q = t1_lat_lo_q;
      `OFS_T1_LAT_HI: rdata_q = t1_lat_hi_q;
      `OFS_T2_CNT_LO: rdata_q = t2_cnt_q[7:0];
      `OFS_T2_CNT_HI: rdata_q = t2_cnt_q[15:8];
      `OFS_SHIFT: rdata_q = serial_shift_reg_q;
      `OFS_AUX_CTRL: rdata_q = aux_control_reg_q;
      `OFS_IFLAG: rdata_q = {any_irq, flags};
      `OFS_IENABLE: rdata_q = {1'b1, ienable_q};
      default: rdata_q = 8'h00;
    endcase
  end

  // control registers
  always @(posedge core_clk) begin
    if (reset) begin
      port_b_output_latch_q <= `RST_BYTE;
      port_b_direction_q <= `RST_BYTE;
      aux_control_reg_q <= `RST_BYTE;
      ienable_q <= 7'h00;
      t1_lat_lo_q <= `RST_BYTE;
      t1_lat_hi_q <= `RST_BYTE;
      t2_lat_lo_q <= `RST_BYTE;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_PORT_B_OUT: port_b_output_latch_q <= wd;
        `OFS_PORT_B_DIR: port_b_direction_q <= wd;
        `OFS_AUX_CTRL: aux_control_reg_q <= wd;
        `OFS_IENABLE: ienable_q <= wd[7] ? (ienable_q | wd[6:0]) : (ienable_q & ~wd[6:0]);
        `OFS_T1_CNT_LO: t1_lat_lo_q <= wd;
        `OFS_T1_LAT_LO: t1_lat_lo_q <= wd;
        `OFS_T1_CNT_HI: t1_lat_hi_q <= wd;
        `OFS_T1_LAT_HI: t1_lat_hi_q <= wd;
        `OFS_T2_CNT_LO: t2_lat_lo_q <= wd;
        default: t2_lat_lo_q <= t2_lat_lo_q;
      endcase
    end
  end

  // timer 1
  always @(posedge core_clk) begin
    if (reset) begin
      t1_cnt_q <= 16'hFFFF;
      t1_armed_q <= 1'b0;
      t1_out_q <= 1'b1;
      t1_flag_q <= 1'b0;
    end else begin
      if (wr_t1_hi) begin
        t1_cnt_q <= {wd, t1_lat_lo_q};
        t1_armed_q <= 1'b1;
        t1_out_q <= 1'b0;
      end else if (t1_zero && t1_free) begin
        t1_cnt_q <= {t1_lat_hi_q, t1_lat_lo_q};
      end else begin
        t1_cnt_q <= t1_cnt_q - 16'h0001;
      end
      if (!wr_t1_hi && t1_zero && t1_armed_q) begin
        t1_armed_q <= t1_free;
        t1_out_q <= t1_free ? !t1_out_q : 1'b1;
      end
      // set wins over a read or flag-write clear in the same cycle; a high write clears
      if (!wr_t1_hi && t1_zero && t1_armed_q) begin
        t1_flag_q <= 1'b1;
      end else if (wr_t1_hi || rd_t1_lo || (wr_flag && wd[`FLAG_T1])) begin
        t1_flag_q <= 1'b0;
      end
    end
  end

  // timer 2
  always @(posedge core_clk) begin
    if (reset) begin
      t2_cnt_q <= 16'hFFFF;
      t2_armed_q <= 1'b0;
      t2_flag_q <= 1'b0;
    end else begin
      if (wr_t2_hi) begin
        t2_cnt_q <= {wd, t2_lat_lo_q};
        t2_armed_q <= 1'b1;
      end else if (t2_dec) begin
        t2_cnt_q <= t2_cnt_q - 16'h0001;
      end
      if (!wr_t2_hi && t2_zero && t2_armed_q) begin
        t2_armed_q <= 1'b0;
        t2_flag_q <= 1'b1;
      end else if (wr_t2_hi || rd_t2_lo || (wr_flag && wd[`FLAG_T2])) begin
        t2_flag_q <= 1'b0;
      end
    end
  end

  // shift register; mode 1 runs off its own divider loaded from the timer 2 low latch
  wire sr_tick = (sr_div_q == 8'h00);
  always @(posedge core_clk) begin
    if (reset) begin
      serial_shift_reg_q <= `RST_BYTE;
      sr_cnt_q <= 4'h0;
      sr_run_q <= 1'b0;
      sr_flag_q <= 1'b0;
      sr_clk_q <= 1'b1;
      sr_div_q <= 8'h00;
      sr_cap_q <= 2'b00;
    end else begin
      sr_div_q <= sr_tick ? t2_lat_lo_q : sr_div_q - 8'h01;
      sr_cap_q <= sr_access ? 2'b00 : {sr_cap_q[0], (sr_mode == 3'd1) && sr_run_q && sr_tick && !sr_clk_q};
      if (wr_sr) begin
        serial_shift_reg_q <= wd;
      end
      case (sr_mode)
        3'd0: begin
          sr_flag_q <= 1'b0;
          sr_run_q <= 1'b0;
          sr_clk_q <= 1'b1;
          if (b1_rise && !wr_sr) begin
            serial_shift_reg_q <= {serial_shift_reg_q[6:0], ctrl_line_b2};
          end
        end
        3'd1: begin
          if (sr_access) begin
            sr_flag_q <= 1'b0;
            sr_cnt_q <= 4'h0;
            sr_run_q <= 1'b1;
            sr_clk_q <= 1'b1;
          end else if (sr_run_q && sr_tick) begin
            sr_clk_q <= !sr_clk_q;
            if (!sr_clk_q) begin
              sr_cnt_q <= sr_cnt_q + 4'h1;
              if (sr_cnt_q == 4'h7) begin
                sr_run_q <= 1'b0;
              end
            end
          end
          // capture a cycle after the pin rises, never in the edge that raises it
          if (sr_cap_q[1] && !sr_access) begin
            serial_shift_reg_q <= {serial_shift_reg_q[6:0], ctrl_line_b2};
            if (sr_cnt_q == 4'h8) begin
              sr_flag_q <= 1'b1;
            end
          end
        end
        3'd2: begin
          if (sr_access) begin
            sr_flag_q <= 1'b0;
            sr_cnt_q <= 4'h0;
            sr_run_q <= 1'b1;
            sr_clk_q <= 1'b0;
          end else if (sr_run_q) begin
            sr_clk_q <= !sr_clk_q;
            if (sr_clk_q) begin
              serial_shift_reg_q <= {serial_shift_reg_q[6:0], ctrl_line_b2};
              sr_cnt_q <= sr_cnt_q + 4'h1;
              if (sr_cnt_q == 4'h7) begin
                sr_run_q <= 1'b0;
                sr_flag_q <= 1'b1;
                sr_clk_q <= 1'b1; // line b1 idles high once the burst ends
              end else begin
                sr_clk_q <= 1'b0;
              end
            end
          end
        end
        default: begin
          sr_run_q <= 1'b0;
          sr_clk_q <= 1'b1;
        end
      endcase
      if (wr_flag && wd[`FLAG_SR] && !(sr_run_q && sr_cnt_q == 4'h7) && !(sr_cap_q[1] && sr_cnt_q == 4'h8)) begin
        sr_flag_q <= 1'b0;
      end
    end
  end

  // pin drivers
  always @(posedge core_clk) begin
    if (reset) begin
      port_b_bit7_timer_pin <= 1'b1;
      port_b_bit7_oe <= 1'b0;
      ctrl_line_b1_out <= 1'b1;
      ctrl_line_b1_oe <= 1'b0;
    end else begin
      port_b_bit7_oe <= port_b_direction_q[7];
      if (port_b_direction_q[7] && aux_control_reg_q[`BIT_T1_PIN_EN]) begin
        port_b_bit7_timer_pin <= t1_out_q;
      end else begin
        port_b_bit7_timer_pin <= port_b_output_latch_q[7];
      end
      ctrl_line_b1_oe <= (sr_mode == 3'd1) || (sr_mode == 3'd2);
      ctrl_line_b1_out <= sr_clk_q;
    end
  end
endmodule
`default_nettype wire

// *** include/dual_timer_map.vh ***
// register offsets, field positions and reset values for the dual timer shift unit
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH
`define OFS_PORT_B_OUT 8'h00
`define OFS_PORT_B_DIR 8'h08
`define OFS_T1_CNT_LO 8'h10
`define OFS_T1_CNT_HI 8'h14
`define OFS_T1_LAT_LO 8'h18
`define OFS_T1_LAT_HI 8'h1C
`define OFS_T2_CNT_LO 8'h20
`define OFS_T2_CNT_HI 8'h24
`define OFS_SHIFT 8'h28
`define OFS_AUX_CTRL 8'h2C
`define OFS_IFLAG 8'h34
`define OFS_IENABLE 8'h38
`define BIT_T1_PIN_EN 7
`define BIT_T1_FREE 6
`define BIT_T2_PULSE 5
`define FLD_SR_MODE_HI 4
`define FLD_SR_MODE_LO 2
`define FLAG_T1 6
`define FLAG_T2 5
`define FLAG_SR 2
`define RST_BYTE 8'h00
`define SYNC_DEPTH 3
`endif

// *** design/edge_sync.v ***
// three-stage synchroniser with agreement-based edge detection
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  input wire core_clk,
  input wire reset,
  input wire async_in,
  output reg level,
  output wire rise,
  output wire fall
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge core_clk) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only once stages two and three agree
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
  assign rise = (s2_q == s3_q) && s3_q && !level;
  assign fall = (s2_q == s3_q) && !s3_q && level;
endmodule
`default_nettype wire

// *** testbench/dual_timer_sva.sv ***
// port assertions for the dual timer shift unit
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_map.vh"
module dual_timer_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic port_b_bit7_timer_pin,
  input wire logic port_b_bit7_oe,
  input wire logic ctrl_line_b1_out,
  input wire logic ctrl_line_b1_oe,
  input wire logic irq_n
);
  logic wa_q;
  logic [7:0] ad_q, aux_q, dir_q, orb_q;
  logic [2:0] hist_q;
  wire [7:0] wd = hwdata[7:0];
  // outputs lag a write, so shadows count only three cycles on
  wire quiet = hist_q == 3'h0 && !wa_q;
  wire [2:0] md = aux_q[`FLD_SR_MODE_HI:`FLD_SR_MODE_LO];
  always @(posedge core_clk) begin
    if (reset) begin
      wa_q <= 1'b0;
      ad_q <= 8'h00;
      aux_q <= 8'h00;
      dir_q <= 8'h00;
      orb_q <= 8'h00;
      hist_q <= 3'h0;
    end else begin
      wa_q <= hsel && hready && htrans[1] && hwrite;
      ad_q <= haddr[7:0];
      hist_q <= {hist_q[1:0], wa_q};
      if (wa_q && ad_q == `OFS_AUX_CTRL) aux_q <= wd;
      if (wa_q && ad_q == `OFS_PORT_B_DIR) dir_q <= wd;
      if (wa_q && ad_q == `OFS_PORT_B_OUT) orb_q <= wd;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  pin_low_a: assert property (wa_q && ad_q == `OFS_T1_CNT_HI && aux_q[7] && dir_q[7] && !aux_q[6]
    |-> ##[1:2] !port_b_bit7_timer_pin) else $error("timer pin not low after start");
  latch_keep_a: assert property (wa_q && ad_q == `OFS_T1_LAT_HI && !aux_q[6]
    |=> $stable(port_b_bit7_timer_pin) [*2]) else $error("latch write moved timer pin");
  plain_pin_a: assert property (quiet && dir_q[7] && !aux_q[7]
    |-> port_b_bit7_timer_pin == orb_q[7]) else $error("pin not from output latch");
  oe_dir_a: assert property (quiet |-> port_b_bit7_oe == dir_q[7]) else $error("pin enable wrong");
  irq_off_a: assert property (wa_q && ad_q == `OFS_IENABLE && wd == 8'h7F |=> irq_n)
    else $error("irq with all enables off");
  b1_idle_a: assert property (quiet && md == 3'h0
    |-> !ctrl_line_b1_oe && ctrl_line_b1_out) else $error("line b1 driven in mode 0");
  b1_drive_a: assert property (quiet && (md == 3'h1 || md == 3'h2)
    |-> ctrl_line_b1_oe) else $error("line b1 not driven");
endmodule
bind dual_timer_shift_unit dual_timer_sva dual_timer_sva_inst (
  .core_clk(core_clk),
  .reset(reset),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .port_b_bit7_timer_pin(port_b_bit7_timer_pin),
  .port_b_bit7_oe(port_b_bit7_oe),
  .ctrl_line_b1_out(ctrl_line_b1_out),
  .ctrl_line_b1_oe(ctrl_line_b1_oe),
  .irq_n(irq_n)
);
`default_nettype wire

// *** testbench/serial_peer.sv ***
// serial peripheral and pulse source beyond port b
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic b1_out,
  input wire logic b1_oe,
  output logic b1_in,
  output logic b2,
  output logic pb6
);
  logic [7:0] tx_q;
  int idx;
  wire b1 = b1_oe ? b1_out : b1_in;
  initial begin
    b1_in = 1'b1;
    b2 = 1'b0;
    pb6 = 1'b1;
    tx_q = 8'h00;
    idx = 7;
  end
  // msb first so the byte lands whole after eight shifts
  always @(negedge b1) begin
    b2 <= tx_q[idx];
    idx <= (idx + 7) % 8;
  end
  task automatic load(input logic [7:0] d);
    tx_q = d;
    idx = 7;
  endtask
  // long high phase keeps data steady past the synchroniser delay
  task automatic clock_in(input int n);
    #33;
    repeat (n) begin
      b1_in = 1'b0;
      #300 b1_in = 1'b1;
      #500;
    end
  endtask
  task automatic pulse(input int n);
    // start off the clock edge so no pin change races the sampler
    #37;
    repeat (n) begin
      #400 pb6 = 1'b0;
      #400 pb6 = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the dual timer shift unit
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_map.vh"
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] v;
  wire [31:0] hrdata;
  wire hreadyout, hresp, port_b_bit7_timer_pin, port_b_bit7_oe, port_b_bit6_count_pin;
  wire ctrl_line_b1_in, ctrl_line_b1_out, ctrl_line_b1_oe, ctrl_line_b2, irq_n;
  int n_fail = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  dual_timer_shift_unit dual_timer_shift_unit_inst (
    .core_clk(core_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .port_b_bit7_timer_pin(port_b_bit7_timer_pin),
    .port_b_bit7_oe(port_b_bit7_oe),
    .port_b_bit6_count_pin(port_b_bit6_count_pin),
    .ctrl_line_b1_in(ctrl_line_b1_in),
    .ctrl_line_b1_out(ctrl_line_b1_out),
    .ctrl_line_b1_oe(ctrl_line_b1_oe),
    .ctrl_line_b2(ctrl_line_b2),
    .irq_n(irq_n)
  );
  serial_peer serial_peer_inst (.b1_out(ctrl_line_b1_out), .b1_oe(ctrl_line_b1_oe),
    .b1_in(ctrl_line_b1_in), .b2(ctrl_line_b2), .pb6(port_b_bit6_count_pin));
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    hsel <= 1'b1;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    v = hrdata[7:0];
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic toggles(input int n, output int t);
    logic p;
    t = 0;
    p = port_b_bit7_timer_pin;
    repeat (n) begin
      @(posedge core_clk);
      if (port_b_bit7_timer_pin !== p) t++;
      p = port_b_bit7_timer_pin;
    end
  endtask
  task automatic t_regs;
    bus(`OFS_AUX_CTRL, 0, 0);
    cmp("aux", `RST_BYTE, v);
    bus(`OFS_IFLAG, 0, 0);
    cmp("flags", `RST_BYTE, v);
    bus(`OFS_IENABLE, 0, 0);
    cmp("enable", 8'h80, v);
    bus(8'h3C, 1, 8'h5A);
    bus(8'h3C, 0, 0);
    cmp("unmapped", 8'h00, v);
    $display("t_regs done");
  endtask
  task automatic t_t1_one;
    bus(`OFS_PORT_B_DIR, 1, 8'h80);
    bus(`OFS_PORT_B_OUT, 1, 8'h80);
    bus(`OFS_AUX_CTRL, 1, 8'h80);
    bus(`OFS_T1_LAT_LO, 1, 8'h40);
    repeat (4) begin
      bus(`OFS_T1_CNT_HI, 1, 8'h00);
      ticks(30);
    end
    bus(`OFS_IFLAG, 0, 0);
    cmp("t1 retrigger", 8'h00, v & 8'h40);
    cmp("t1 pin low", 8'h00, {7'h0, port_b_bit7_timer_pin});
    // a loaded high latch would stretch this period past the wait
    bus(`OFS_T1_LAT_HI, 1, 8'h01);
    ticks(70);
    bus(`OFS_IFLAG, 0, 0);
    cmp("t1 flag", 8'h40, v & 8'h40);
    cmp("t1 pin high", 8'h01, {7'h0, port_b_bit7_timer_pin});
    bus(`OFS_T1_CNT_LO, 0, 0);
    bus(`OFS_IFLAG, 0, 0);
    cmp("t1 clear", 8'h00, v & 8'h40);
    $display("t_t1_one done");
  endtask
  task automatic t_t1_free;
    int t;
    bus(`OFS_T1_LAT_HI, 1, 8'h00);
    bus(`OFS_T1_LAT_LO, 1, 8'h10);
    bus(`OFS_AUX_CTRL, 1, 8'hC0);
    bus(`OFS_T1_CNT_HI, 1, 8'h00);
    toggles(170, t);
    cmp("fast toggles", 8'h01, {7'h0, t >= 9 && t <= 10});
    bus(`OFS_T1_LAT_LO, 1, 8'h30);
    toggles(200, t);
    cmp("slow toggles", 8'h01, {7'h0, t >= 4 && t <= 5});
    bus(`OFS_IFLAG, 1, 8'h40);
    bus(`OFS_IFLAG, 0, 0);
    cmp("flag write", 8'h00, v & 8'h40);
    ticks(60);
    bus(`OFS_IFLAG, 0, 0);
    cmp("free reflag", 8'h40, v & 8'h40);
    bus(`OFS_PORT_B_OUT, 1, 8'h00);
    bus(`OFS_AUX_CTRL, 1, 8'h40);
    ticks(4);
    cmp("plain pin", 8'h00, {7'h0, port_b_bit7_timer_pin});
    $display("t_t1_free done");
  endtask
  task automatic t_t2;
    bus(`OFS_AUX_CTRL, 1, 8'h00);
    bus(`OFS_T2_CNT_LO, 1, 8'h20);
    bus(`OFS_T2_CNT_HI, 1, 8'h00);
    ticks(40);
    bus(`OFS_IFLAG, 0, 0);
    cmp("t2 flag", 8'h20, v & 8'h20);
    bus(`OFS_T2_CNT_LO, 0, 0);
    bus(`OFS_IFLAG, 0, 0);
    cmp("t2 read clear", 8'h00, v & 8'h20);
    bus(`OFS_AUX_CTRL, 1, 8'h20);
    bus(`OFS_T2_CNT_LO, 1, 8'h03);
    bus(`OFS_T2_CNT_HI, 1, 8'h00);
    serial_peer_inst.pulse(2);
    ticks(6);
    bus(`OFS_T2_CNT_LO, 0, 0);
    cmp("pulse count", 8'h01, v);
    serial_peer_inst.pulse(3);
    ticks(6);
    bus(`OFS_IFLAG, 0, 0);
    cmp("pulse flag", 8'h20, v & 8'h20);
    bus(`OFS_T2_CNT_HI, 1, 8'h00);
    bus(`OFS_IFLAG, 0, 0);
    cmp("t2 write clear", 8'h00, v & 8'h20);
    $display("t_t2 done");
  endtask
  task automatic t_shift;
    int k;
    bus(`OFS_AUX_CTRL, 1, 8'h00);
    bus(`OFS_IENABLE, 1, 8'h84);
    serial_peer_inst.load(8'hA5);
    serial_peer_inst.clock_in(8);
    ticks(8);
    bus(`OFS_SHIFT, 0, 0);
    cmp("mode 0 data", 8'hA5, v);
    cmp("mode 0 irq", 8'h01, {7'h0, irq_n});
    bus(`OFS_T2_CNT_LO, 1, 8'h02);
    serial_peer_inst.load(8'h3C);
    bus(`OFS_AUX_CTRL, 1, 8'h04);
    bus(`OFS_SHIFT, 0, 0);
    k = 0;
    while (irq_n !== 1'b0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    cmp("mode 1 irq", 8'h00, {7'h0, irq_n});
    bus(`OFS_SHIFT, 0, 0);
    cmp("mode 1 data", 8'h3C, v);
    ticks(100);
    serial_peer_inst.load(8'hC3);
    bus(`OFS_AUX_CTRL, 1, 8'h08);
    bus(`OFS_SHIFT, 0, 0);
    ticks(40);
    cmp("mode 2 irq", 8'h00, {7'h0, irq_n});
    bus(`OFS_SHIFT, 0, 0);
    cmp("mode 2 data", 8'hC3, v);
    bus(`OFS_IENABLE, 1, 8'h7F);
    ticks(1);
    cmp("irq off", 8'h01, {7'h0, irq_n});
    $display("t_shift done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    ticks(16);
    reset <= 1'b0;
    ticks(1);
    t_regs;
    t_t1_one;
    t_t1_free;
    t_t2;
    t_shift;
    tally_and_finish;
  end
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
